// File: core/rcchk_top.sv
// Reconfiguration controller error checker: illegal-request checks,
// timeout self-recovery, simulation offset cancellation, AXI4-Lite regs.
// Assumes one clock MCLK; user requests are synchronous single-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
`include "rcchk_defs.svh"

// What this block does
// R1: Error output exists only when a check enabled
// R2: Illegal request: busy drops, error two cycles
// R3: Read illegal without any readback outputs
// R4: Write-all illegal without any write inputs
// R5: Read illegal in channel-reconfiguration mode
// R6: Abandon operations exceeding expected cycle count
// R7: After timeout, busy drops, error two cycles
// R8: Out-of-range analog values never raise error
// R9: Simulation offset cancellation lasts 16 cycles
// R10: Power-down stays low during offset cancellation; POWER_DOWN is not used here, the user model holds it low
// R11: Illegal requests perform no reconfiguration work
module rcchk_top
   import rcchk_pkg::*;
#(
   parameter bit          ILLEGAL_CHECK_EN = 1'b1,
   parameter bit          SELF_RECOVER_EN  = 1'b1,
   parameter logic [3:0]  READBACK_EN      = 4'hF,
   parameter logic [3:0]  WRITE_EN         = 4'hF,
   parameter int unsigned OP_TIMEOUT       = `RCCHK_OP_TIMEOUT,
   parameter int unsigned OC_CYCLES        = `RCCHK_OC_SIM_CYCLES
) (
   // Clock and reset
   input  wire logic        MCLK,
   input  wire logic        RST_N,
   // User request side
   input  wire logic        READ,
   input  wire logic        WRITE_ALL,
   input  wire logic [2:0]  MODE_SEL,
   input  wire logic        POWER_DOWN,
   output logic             BUSY,
   output logic             ERROR,
   // Datapath side
   output logic             OP_START,
   output logic [1:0]       OP_KIND,
   input  wire logic        OP_DONE,
   output logic             OP_ABORT,
   output logic             OC_ACTIVE,
   // AXI4-Lite slave
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // Interrupt
   output logic             IRQ
);

   // Counter width covers the default timeout with room to spare
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] TIMEOUT_C = CNT_W'(OP_TIMEOUT);
   localparam logic [CNT_W-1:0] OC_C      = CNT_W'(OC_CYCLES);
   // Error output only present when some check is built in
   localparam bit ERR_PRESENT = ILLEGAL_CHECK_EN || SELF_RECOVER_EN;

   // All state in one record so reset and update stay a single assignment
   typedef struct packed {
      rcchk_state_type          state;
      rcchk_op_type             op;
      logic                     illegal;
      logic [CNT_W-1:0]         cnt;
      logic [1:0]               err_cnt;
      logic                     error;
      logic                     start;
      logic                     abort;
      logic [`RCCHK_IRQ_W-1:0]  irq_stat;
      logic [`RCCHK_IRQ_W-1:0]  irq_en;
      logic                     aw_got;
      logic                     w_got;
      logic [7:0]               awaddr;
      logic [31:0]              wdata;
      logic [3:0]               wstrb;
      logic                     bvalid;
      logic [1:0]               bresp;
      logic                     rvalid;
      logic [31:0]              rdata;
      logic [1:0]               rresp;
   } rcchk_regs_type;

   // r is the only state; next_r is its combinational successor
   rcchk_regs_type r, next_r;

   // Decides whether a request is illegal for this build
   function automatic logic is_illegal(input rcchk_op_type op, input logic [2:0] mode);
      logic bad;
      bad = 1'b0;
      if (op == RCCHK_OP_READ && READBACK_EN == 4'h0)
         bad = 1'b1;                                      // [R3]
      if (op == RCCHK_OP_WRALL && WRITE_EN == 4'h0)
         bad = 1'b1;                                      // [R4]
      if (op == RCCHK_OP_READ && mode == `RCCHK_MODE_CHANNEL)
         bad = 1'b1;                                      // [R5]
      return bad && ILLEGAL_CHECK_EN;
   endfunction

   // Register address match on word offsets
   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
      return {a[7:2], 2'h0} == off;
   endfunction

   // Strobes decoded from the register bus, used only inside the next-state logic
   logic wr_fire;
   logic rd_fire;
   logic oc_start_wr;
   logic [`RCCHK_IRQ_W-1:0] clr_bits;

   // Next-state logic for sequencer and register slave
   always_comb begin
      next_r = r;
      next_r.start = 1'b0;
      next_r.abort = 1'b0;
      oc_start_wr = 1'b0;
      clr_bits = '0;

      // AXI write: address and data taken in either order
      // Writes to read-only words are answered OKAY and have no effect
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         next_r.aw_got = 1'b1;
         next_r.awaddr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         next_r.w_got = 1'b1;
         next_r.wdata = S_AXI_WDATA;
         next_r.wstrb = S_AXI_WSTRB;
      end
      wr_fire = r.aw_got && r.w_got && !r.bvalid;
      if (wr_fire) begin
         next_r.aw_got = 1'b0;
         next_r.w_got  = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp  = `RCCHK_RESP_OKAY;
         if (addr_is(r.awaddr, `RCCHK_REG_CTRL)) begin
            oc_start_wr = r.wstrb[0] && r.wdata[`RCCHK_CTRL_OC_START];
         end else if (addr_is(r.awaddr, `RCCHK_REG_IRQ_EN)) begin
            if (r.wstrb[0])
               next_r.irq_en = r.wdata[`RCCHK_IRQ_W-1:0];
         end else if (addr_is(r.awaddr, `RCCHK_REG_IRQ_CLR)) begin
            if (r.wstrb[0])
               clr_bits = r.wdata[`RCCHK_IRQ_W-1:0];
         end else if (!addr_is(r.awaddr, `RCCHK_REG_STATUS) && !addr_is(r.awaddr, `RCCHK_REG_IRQ_STAT)) begin
            next_r.bresp = `RCCHK_RESP_SLVERR;
         end
      end
      if (r.bvalid && S_AXI_BREADY)
         next_r.bvalid = 1'b0;

      // AXI read
      // Read data is registered so RDATA holds while RVALID waits for RREADY
      rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
      if (rd_fire) begin
         next_r.rvalid = 1'b1;
         next_r.rresp  = `RCCHK_RESP_OKAY;
         next_r.rdata  = '0;
         if (addr_is(S_AXI_ARADDR, `RCCHK_REG_STATUS)) begin
            next_r.rdata[`RCCHK_ST_BUSY] = BUSY;
            next_r.rdata[`RCCHK_ST_OC]   = (r.state == RCCHK_OFFSET);
         end else if (addr_is(S_AXI_ARADDR, `RCCHK_REG_IRQ_STAT))
            next_r.rdata[`RCCHK_IRQ_W-1:0] = r.irq_stat;
         else if (addr_is(S_AXI_ARADDR, `RCCHK_REG_IRQ_EN))
            next_r.rdata[`RCCHK_IRQ_W-1:0] = r.irq_en;
         else if (!addr_is(S_AXI_ARADDR, `RCCHK_REG_CTRL) && !addr_is(S_AXI_ARADDR, `RCCHK_REG_IRQ_CLR))
            next_r.rresp = `RCCHK_RESP_SLVERR;
      end else if (r.rvalid && S_AXI_RREADY)
         next_r.rvalid = 1'b0;

      // Clear first so a same-cycle event below wins
      next_r.irq_stat = r.irq_stat & ~clr_bits;

      // Error pulse counts down independently of the sequencer
      if (r.err_cnt != 2'h0)
         next_r.err_cnt = r.err_cnt - 2'h1;
      next_r.error = ERR_PRESENT && (next_r.err_cnt != 2'h0);  // [R1]

      // Request sequencer
      unique case (r.state)
         RCCHK_IDLE: begin
            // A request in the same cycle as an offset start wins; that write is lost
            if (READ || WRITE_ALL) begin
               next_r.op = READ ? RCCHK_OP_READ : RCCHK_OP_WRALL;
               // Latch the verdict now; mode may move next cycle
               next_r.illegal = is_illegal(READ ? RCCHK_OP_READ : RCCHK_OP_WRALL, MODE_SEL);
               next_r.state = RCCHK_CHECK;
            end else if (oc_start_wr) begin
               next_r.cnt = '0;
               next_r.state = RCCHK_OFFSET;
            end
         end
         RCCHK_CHECK: begin
            // Second cycle: verdict acted on, inside the two-cycle budget
            if (r.illegal) begin
               next_r.state   = RCCHK_ERROR;                       // [R11]
               next_r.err_cnt = `RCCHK_ERR_CYCLES;                 // [R2]
               next_r.error   = ERR_PRESENT;
               next_r.irq_stat[`RCCHK_IRQ_ILLEGAL] = 1'b1;
            end else begin
               // Analog values are not range-checked here on purpose
               next_r.start = 1'b1;                                // [R8]
               next_r.cnt   = '0;
               next_r.state = RCCHK_RUN;
            end
         end
         RCCHK_RUN: begin
            next_r.cnt = r.cnt + CNT_W'(1);
            // Done on the limit cycle still counts as done, not as a timeout
            if (OP_DONE)
               next_r.state = RCCHK_IDLE;
            else if (SELF_RECOVER_EN && r.cnt >= TIMEOUT_C - CNT_W'(1)) begin
               next_r.abort   = 1'b1;                              // [R6]
               next_r.state   = RCCHK_ERROR;
               next_r.err_cnt = `RCCHK_ERR_CYCLES;                 // [R7]
               next_r.error   = ERR_PRESENT;
               next_r.irq_stat[`RCCHK_IRQ_TIMEOUT] = 1'b1;
            end
         end
         RCCHK_ERROR: begin
            // Requests are dropped here; the user waits for error to fall
            if (r.err_cnt == 2'h1)
               next_r.state = RCCHK_IDLE;
         end
         RCCHK_OFFSET: begin
            // Requests are ignored until the sequence ends; none may cut it short
            next_r.cnt = r.cnt + CNT_W'(1);
            if (r.cnt == OC_C - CNT_W'(1)) begin                   // [R9]
               next_r.state = RCCHK_IDLE;
               next_r.irq_stat[`RCCHK_IRQ_OC_DONE] = 1'b1;
            end
         end
         default: next_r.state = RCCHK_IDLE;
      endcase
   end

   // Single state register
   // Reset leaves the bus readies high because they derive from empty flags
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N)
         r <= '0;
      else
         r <= next_r;
   end

   // Outputs; busy is low while error shows
   // Readies are combinational so an idle slave takes address and data at once
   assign BUSY          = (r.state == RCCHK_CHECK) || (r.state == RCCHK_RUN) || (r.state == RCCHK_OFFSET);
   assign ERROR         = r.error;
   assign OP_START      = r.start;
   assign OP_KIND       = r.op;
   assign OP_ABORT      = r.abort;
   assign OC_ACTIVE     = (r.state == RCCHK_OFFSET);
   assign S_AXI_AWREADY = !r.aw_got && !r.bvalid;
   assign S_AXI_WREADY  = !r.w_got && !r.bvalid;
   assign S_AXI_BVALID  = r.bvalid;
   assign S_AXI_BRESP   = r.bresp;
   assign S_AXI_ARREADY = !r.rvalid;
   assign S_AXI_RVALID  = r.rvalid;
   assign S_AXI_RDATA   = r.rdata;
   assign S_AXI_RRESP   = r.rresp;
   assign IRQ           = |(r.irq_stat & r.irq_en);

   // Checks on error timing and sequencing
   // They check only what this block drives; user inputs are left to the bench
   AST_ERR_TWO: assert property (@(posedge MCLK) disable iff (!RST_N)  // [R2]
      $rose(ERROR) |-> ERROR ##1 ERROR ##1 !ERROR)
      else $error("error pulse not two cycles");
   AST_ILLEGAL_FAST: assert property (@(posedge MCLK) disable iff (!RST_N)  // [R2]
      (r.state == RCCHK_IDLE && READ && is_illegal(RCCHK_OP_READ, MODE_SEL)) |-> ##[1:2] (ERROR && !BUSY))
      else $error("illegal read not flagged in time");
   AST_CHAN_READ: assert property (@(posedge MCLK) disable iff (!RST_N)  // [R5]
      (ILLEGAL_CHECK_EN && r.state == RCCHK_IDLE && READ && MODE_SEL == `RCCHK_MODE_CHANNEL) |-> ##2 ERROR)
      else $error("channel-mode read not flagged");
   AST_NO_START: assert property (@(posedge MCLK) disable iff (!RST_N)  // [R11]
      (r.state == RCCHK_CHECK && r.illegal) |-> ##1 (!OP_START [*2]))
      else $error("illegal request started datapath");
   AST_TIMEOUT: assert property (@(posedge MCLK) disable iff (!RST_N)  // [R6]
      OP_ABORT |-> (ERROR && !BUSY && $past(r.state) == RCCHK_RUN))
      else $error("abort without error");
   AST_ERR_NOBUSY: assert property (@(posedge MCLK) disable iff (!RST_N)  // [R7]
      ERROR |-> !BUSY)
      else $error("busy during error");
   AST_NO_ERR_OPT: assert property (@(posedge MCLK) disable iff (!RST_N)  // [R1]
      !ERR_PRESENT |-> !ERROR)
      else $error("error without option");
   AST_OC_LEN: assert property (@(posedge MCLK) disable iff (!RST_N)  // [R9]
      $rose(OC_ACTIVE) |-> (OC_ACTIVE && r.cnt < OC_C) ##(OC_CYCLES) !OC_ACTIVE)
      else $error("offset cancellation length wrong");
   AST_LEGAL_OK: assert property (@(posedge MCLK) disable iff (!RST_N)  // [R8]
      (r.state == RCCHK_CHECK && !r.illegal) |-> ##1 (OP_START && !ERROR))
      else $error("legal request flagged");
   AST_OC_QUIET: assert property (@(posedge MCLK) disable iff (!RST_N)  // [R9]
      OC_ACTIVE |-> (BUSY && !ERROR && !OP_START))
      else $error("offset cancellation not exclusive");
   AST_READ_NOBACK: assert property (@(posedge MCLK) disable iff (!RST_N)  // [R3]
      (ILLEGAL_CHECK_EN && READBACK_EN == 4'h0 && r.state == RCCHK_IDLE && READ) |-> ##2 (ERROR && !BUSY))
      else $error("read without readback not flagged");
   AST_WRALL_NOPORT: assert property (@(posedge MCLK) disable iff (!RST_N)  // [R4]
      (ILLEGAL_CHECK_EN && WRITE_EN == 4'h0 && r.state == RCCHK_IDLE && WRITE_ALL && !READ) |-> ##2 (ERROR && !BUSY))
      else $error("write-all without write ports not flagged");
   AST_BUSY_BEFORE: assert property (@(posedge MCLK) disable iff (!RST_N)  // [R2] [R7]
      $rose(ERROR) |-> $past(BUSY))
      else $error("error not preceded by busy");
   AST_RUN_BOUND: assert property (@(posedge MCLK) disable iff (!RST_N)  // [R6]
      (SELF_RECOVER_EN && r.state == RCCHK_RUN) |-> (r.cnt < TIMEOUT_C))
      else $error("operation ran past its limit");
   AST_ABORT_ONE: assert property (@(posedge MCLK) disable iff (!RST_N)  // [R7]
      OP_ABORT |=> !OP_ABORT)
      else $error("abort longer than one cycle");

   // Bus answers must hold until the master takes them
   AST_BVALID_HOLD: assert property (@(posedge MCLK) disable iff (!RST_N)  // Write response handshake
      (S_AXI_BVALID && !S_AXI_BREADY) |=> (S_AXI_BVALID && $stable(S_AXI_BRESP)))
      else $error("write response dropped early");
   AST_RVALID_HOLD: assert property (@(posedge MCLK) disable iff (!RST_N)  // Read data handshake
      (S_AXI_RVALID && !S_AXI_RREADY) |=> (S_AXI_RVALID && $stable(S_AXI_RDATA)))
      else $error("read data dropped early");

   COV_ILLEGAL: cover property (@(posedge MCLK) disable iff (!RST_N) $rose(r.irq_stat[`RCCHK_IRQ_ILLEGAL]));
   COV_TIMEOUT: cover property (@(posedge MCLK) disable iff (!RST_N) OP_ABORT);
   COV_DONE: cover property (@(posedge MCLK) disable iff (!RST_N) r.state == RCCHK_RUN && OP_DONE);
   COV_OC: cover property (@(posedge MCLK) disable iff (!RST_N) $fell(OC_ACTIVE));
   COV_WRALL_BAD: cover property (@(posedge MCLK) disable iff (!RST_N)
      r.state == RCCHK_CHECK && r.illegal && r.op == RCCHK_OP_WRALL);

endmodule

`default_nettype wire

// File: core/rcchk_defs.svh
// Constants for the reconfiguration error checker.
// Assumes inclusion by the package, the top module and the bench.
`ifndef RCCHK_DEFS_SVH
`define RCCHK_DEFS_SVH

// Operation-select code for channel reconfiguration
`define RCCHK_MODE_CHANNEL     3'h1
`define RCCHK_MODE_W           3
// Error pulse length in controller cycles
`define RCCHK_ERR_CYCLES       2'h2
// Offset cancellation duration in simulation model, cycles
`define RCCHK_OC_SIM_CYCLES    16
// Default expected operation length, cycles
`define RCCHK_OP_TIMEOUT       256
// AXI register offsets
`define RCCHK_REG_CTRL         8'h00
`define RCCHK_REG_STATUS       8'h04
`define RCCHK_REG_IRQ_STAT     8'h08
`define RCCHK_REG_IRQ_EN       8'h0C
`define RCCHK_REG_IRQ_CLR      8'h10
// Field positions
`define RCCHK_CTRL_OC_START    0
`define RCCHK_ST_BUSY          0
`define RCCHK_ST_OC            1
`define RCCHK_IRQ_ILLEGAL      0
`define RCCHK_IRQ_TIMEOUT      1
`define RCCHK_IRQ_OC_DONE      2
`define RCCHK_IRQ_W            3
// AXI responses
`define RCCHK_RESP_OKAY        2'h0
`define RCCHK_RESP_SLVERR      2'h2

`endif

// File: core/rcchk_pkg.sv
// Types for the reconfiguration error checker.
// Assumes rcchk_defs.svh is on the include path.
`default_nettype none
`include "rcchk_defs.svh"

package rcchk_pkg;

   // Controller sequencing states
   typedef enum logic [2:0] {
      RCCHK_IDLE    = 3'h0,
      RCCHK_CHECK   = 3'h1,
      RCCHK_RUN     = 3'h2,
      RCCHK_ERROR   = 3'h3,
      RCCHK_OFFSET  = 3'h4
   } rcchk_state_type;

   // Kind of operation requested
   typedef enum logic [1:0] {
      RCCHK_OP_NONE  = 2'h0,
      RCCHK_OP_READ  = 2'h1,
      RCCHK_OP_WRALL = 2'h2
   } rcchk_op_type;

endpackage

`default_nettype wire

// File: testbench/rcchk_user_model.sv
// User-side model: issues requests and plays the reconfiguration datapath.
// Assumes one rising-edge clock shared with the checker.
`timescale 1ns/10ps
`default_nettype none
module rcchk_user_model (
   // Clock and datapath start
   input  wire logic       mclk,
   input  wire logic       op_start,
   // Requests and datapath answer
   output logic            read,
   output logic            write_all,
   output logic [2:0]      mode_sel,
   output logic            power_down,
   output logic            op_done
);
   int done_delay = 3; // Zero: datapath never answers
   int cnt = 0;
   // Power-down stays low so offset cancellation is never disturbed
   initial begin
      read = 1'b0;
      write_all = 1'b0;
      mode_sel = 3'h0;
      power_down = 1'b0;
      op_done = 1'b0;
   end
   // One-cycle request pulse; select held with it
   task automatic request(input logic rd, input logic [2:0] mode);
      @(posedge mclk);
      read <= rd;
      write_all <= !rd;
      mode_sel <= mode;
      @(posedge mclk);
      read <= 1'b0;
      write_all <= 1'b0;
   endtask
   // Completion after a set delay, or never when a timeout is wanted
   always @(posedge mclk) begin
      if (op_start === 1'b1 && done_delay > 0) begin
         cnt <= done_delay;
         op_done <= 1'b0;
      end else begin
         if (cnt > 0) cnt <= cnt - 1;
         op_done <= (cnt == 1);
      end
   end
endmodule
`default_nettype wire

// File: testbench/rcchk_top_tb.sv
// Bench for the reconfiguration error checker: request timing, timeout,
// offset cancellation and the register and interrupt path.
// Assumes rcchk_defs.svh on the include path and the user model alongside.
`timescale 1ns/10ps
`default_nettype none
`include "rcchk_defs.svh"
module rcchk_top_tb;
   localparam int TMO = 16; // Short timeout keeps the run brief
   logic mclk, rst_n, read, write_all, power_down, op_start, op_done, op_abort;
   logic oc_active, busy, error, irq, awvalid, awready, wvalid, wready, bvalid;
   logic bready, arvalid, arready, rvalid, rready;
   logic busy_bare, error_bare, start_bare;
   logic [2:0]  mode_sel;
   logic [1:0]  op_kind, bresp, rresp;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   int fail_count = 0;
   int num_checks = 0;
   int oc_len = 0;
   // 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Length of offset cancellation, counted edge by edge
   always @(posedge mclk) if (oc_active === 1'b1) oc_len++;
   rcchk_top #(.OP_TIMEOUT(TMO)) dut (.MCLK(mclk), .RST_N(rst_n), .READ(read), .WRITE_ALL(write_all),
      .MODE_SEL(mode_sel), .POWER_DOWN(power_down), .BUSY(busy), .ERROR(error), .OP_START(op_start),
      .OP_KIND(op_kind), .OP_DONE(op_done), .OP_ABORT(op_abort), .OC_ACTIVE(oc_active),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .IRQ(irq));
   rcchk_user_model u_user (.mclk(mclk), .op_start(op_start), .read(read), .write_all(write_all),
      .mode_sel(mode_sel), .power_down(power_down), .op_done(op_done));
   // Second build with no readback or write ports: every request is illegal
   rcchk_top #(.READBACK_EN(4'h0), .WRITE_EN(4'h0)) dut_bare (.MCLK(mclk), .RST_N(rst_n), .READ(read),
      .WRITE_ALL(write_all), .MODE_SEL(mode_sel), .POWER_DOWN(power_down), .BUSY(busy_bare),
      .ERROR(error_bare), .OP_START(start_bare), .OP_KIND(), .OP_DONE(1'b0), .OP_ABORT(), .OC_ACTIVE(),
      .S_AXI_AWADDR(8'h00), .S_AXI_AWVALID(1'b0), .S_AXI_AWREADY(), .S_AXI_WDATA(32'h0), .S_AXI_WSTRB(4'h0),
      .S_AXI_WVALID(1'b0), .S_AXI_WREADY(), .S_AXI_BRESP(), .S_AXI_BVALID(), .S_AXI_BREADY(1'b0),
      .S_AXI_ARADDR(8'h00), .S_AXI_ARVALID(1'b0), .S_AXI_ARREADY(), .S_AXI_RDATA(), .S_AXI_RRESP(),
      .S_AXI_RVALID(), .S_AXI_RREADY(1'b0), .IRQ());
   // Verdict and end of run
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // A bounded wait ran out
   task automatic hang;
      check(32'h0, 32'h1);
      conclude();
   endtask
   // Step to just after the next edge, where outputs have settled
   task automatic step;
      @(posedge mclk);
      #1;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit got_b;
      got_b = 1'b0;
      @(posedge mclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 40 && !got_b; n++) begin
         @(posedge mclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            got_b = 1'b1;
         end
      end
      if (!got_b) hang();
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit got_r;
      got_r = 1'b0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 40 && !got_r; n++) begin
         @(posedge mclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            got_r = 1'b1;
         end
      end
      if (!got_r) hang();
   endtask
   task automatic wr_chk(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      check(32'(r), 32'(`RCCHK_RESP_OKAY));
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(a, d, r);
      check(32'(r), 32'(er));
      if (er == `RCCHK_RESP_OKAY) check(d, e);
   endtask
   // One request, judged cycle by cycle against the request timing
   task automatic do_req(input logic rd, input logic [2:0] m);
      logic bad;
      int   n;
      bad = rd && (m == `RCCHK_MODE_CHANNEL);
      u_user.request(rd, m);
      #1;
      check(32'(busy), 32'h1);
      step;
      check(32'({busy_bare, error_bare, start_bare}), 32'h2);
      if (bad) begin
         check(32'({busy, error, op_start}), 32'h2);
         step;
         check(32'({error, op_start}), 32'h2);
         step;
         check(32'({busy, error}), 32'h0);
      end else begin
         check(32'({op_start, op_kind}), rd ? 32'h5 : 32'h6);
         n = 0;
         while (busy === 1'b1 && n < 20) begin
            step;
            n++;
         end
         if (n == 20) hang();
         check(32'(error), 32'h0);
      end
   endtask
   // Illegal flag reaches the interrupt only when enabled
   task automatic irq_path;
      rd_chk(`RCCHK_REG_IRQ_STAT, 32'h1, `RCCHK_RESP_OKAY);
      check(32'(irq), 32'h0);
      wr_chk(`RCCHK_REG_IRQ_EN, 32'h7);
      step;
      check(32'(irq), 32'h1);
      rd_chk(`RCCHK_REG_IRQ_EN, 32'h7, `RCCHK_RESP_OKAY);
      wr_chk(`RCCHK_REG_IRQ_CLR, 32'h1);
      step;
      check(32'(irq), 32'h0);
      rd_chk(`RCCHK_REG_IRQ_STAT, 32'h0, `RCCHK_RESP_OKAY);
   endtask
   // Datapath stays silent; the operation must be abandoned on time
   task automatic timeout_op;
      int n;
      u_user.done_delay = 0;
      u_user.request(1'b1, 3'h0);
      #1;
      step;
      check(32'(op_start), 32'h1);
      n = 0;
      while (error !== 1'b1 && n < 100) begin
         step;
         n++;
      end
      if (n == 100) hang();
      check(32'(n), 32'(TMO));
      check(32'({op_abort, busy}), 32'h2);
      step;
      check(32'({error, op_abort}), 32'h2);
      step;
      check(32'(error), 32'h0);
      u_user.done_delay = 3;
      check(32'(irq), 32'h1);
      rd_chk(`RCCHK_REG_IRQ_STAT, 32'h2, `RCCHK_RESP_OKAY);
      wr_chk(`RCCHK_REG_IRQ_CLR, 32'h2);
   endtask
   task automatic oc_run;
      int n;
      oc_len = 0;
      wr_chk(`RCCHK_REG_CTRL, 32'h1);
      rd_chk(`RCCHK_REG_STATUS, 32'h3, `RCCHK_RESP_OKAY);
      n = 0;
      while (!(oc_len > 0 && oc_active !== 1'b1) && n < 60) begin
         step;
         n++;
      end
      if (n == 60) hang();
      check(32'(oc_len), 32'(`RCCHK_OC_SIM_CYCLES));
      check(32'(busy), 32'h0);
      rd_chk(`RCCHK_REG_IRQ_STAT, 32'h4, `RCCHK_RESP_OKAY);
   endtask
   // Watchdog against a hung run
   initial begin
      #200000;
      hang();
   end
   initial begin
      rst_n = 1'b0;
      awaddr = 8'h00;
      awvalid = 1'b0;
      wdata = 32'h0;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 8'h00;
      arvalid = 1'b0;
      rready = 1'b0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      for (int m = 0; m < 8; m++) begin
         do_req(1'b0, 3'(m));
         do_req(1'b1, 3'(m));
      end
      irq_path();
      timeout_op();
      oc_run();
      rd_chk(8'hF0, 32'h0, `RCCHK_RESP_SLVERR);
      conclude();
   end
endmodule
`default_nettype wire
